/* File: logic/stc_pkg.sv */
package stc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] STC_OFS_TRACK  = 8'h1a;
  localparam logic [7:0] STC_OFS_THRESH = 8'h1b;
  localparam logic [7:0] STC_OFS_REGION = 8'h1c;
  localparam logic [7:0] STC_OFS_REVTS  = 8'h1d;

  // ==========================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] STC_RST_TRACK  = 8'h20;
  localparam logic [7:0] STC_RST_THRESH = 8'h96;
  localparam logic [7:0] STC_RST_REGION = 8'h57;
  localparam logic [7:0] STC_RST_REVTS  = 8'h40;
  localparam logic [7:0] STC_WM_TRACK   = 8'he7;
  localparam logic [7:0] STC_WM_THRESH  = 8'hff;
  localparam logic [7:0] STC_WM_REGION  = 8'h7f;
  localparam logic [7:0] STC_WM_REVTS   = 8'he0;

  // ==========================================================
  // Field positions (low bit of each field)
  localparam int STC_B_SWEEP      = 7;
  localparam int STC_B_PO_LO      = 5;
  localparam int STC_B_SCAN_LO    = 1;
  localparam int STC_B_TRACK_ON   = 0;
  localparam int STC_B_HOT_LO     = 6;
  localparam int STC_B_WARM_LO    = 4;
  localparam int STC_B_COOL_LO    = 2;
  localparam int STC_B_COLD_LO    = 0;
  localparam int STC_B_WARM_V_LO  = 5;
  localparam int STC_B_WARM_I     = 4;
  localparam int STC_B_COOL_I_LO  = 2;
  localparam int STC_B_PROFILE_ON = 1;
  localparam int STC_B_THERM_ON   = 0;
  localparam int STC_B_RHOT_LO    = 6;
  localparam int STC_B_RCOLD      = 5;

  // ==========================================================
  // Interval times and cycle counts at 200 MHz
  localparam longint STC_CLK_KHZ     = 200000;
  localparam longint STC_PO_A_MS     = 500;
  localparam longint STC_PO_B_MS     = 1000;
  localparam longint STC_PO_C_MS     = 10000;
  localparam longint STC_SCAN_A_MIN  = 3;
  localparam longint STC_SCAN_B_MIN  = 10;
  localparam longint STC_SCAN_C_MIN  = 15;
  localparam longint STC_SCAN_D_MIN  = 20;
  localparam longint STC_MS_PER_MIN  = 60000;
  localparam logic [39:0] STC_PO_A_CYC   = 40'(STC_PO_A_MS * STC_CLK_KHZ);
  localparam logic [39:0] STC_PO_B_CYC   = 40'(STC_PO_B_MS * STC_CLK_KHZ);
  localparam logic [39:0] STC_PO_C_CYC   = 40'(STC_PO_C_MS * STC_CLK_KHZ);
  localparam logic [39:0] STC_SCAN_A_CYC = 40'(STC_SCAN_A_MIN * STC_MS_PER_MIN * STC_CLK_KHZ);
  localparam logic [39:0] STC_SCAN_B_CYC = 40'(STC_SCAN_B_MIN * STC_MS_PER_MIN * STC_CLK_KHZ);
  localparam logic [39:0] STC_SCAN_C_CYC = 40'(STC_SCAN_C_MIN * STC_MS_PER_MIN * STC_CLK_KHZ);
  localparam logic [39:0] STC_SCAN_D_CYC = 40'(STC_SCAN_D_MIN * STC_MS_PER_MIN * STC_CLK_KHZ);

  // ==========================================================
  // Thermistor ratios in units of 0.001 %
  localparam logic [16:0] STC_R_31250 = 17'd31250;
  localparam logic [16:0] STC_R_34200 = 17'd34200;
  localparam logic [16:0] STC_R_34375 = 17'd34375;
  localparam logic [16:0] STC_R_37700 = 17'd37700;
  localparam logic [16:0] STC_R_41200 = 17'd41200;
  localparam logic [16:0] STC_R_44800 = 17'd44800;
  localparam logic [16:0] STC_R_48400 = 17'd48400;
  localparam logic [16:0] STC_R_62400 = 17'd62400;
  localparam logic [16:0] STC_R_65500 = 17'd65500;
  localparam logic [16:0] STC_R_68400 = 17'd68400;
  localparam logic [16:0] STC_R_71100 = 17'd71100;
  localparam logic [16:0] STC_R_73250 = 17'd73250;
  localparam logic [16:0] STC_R_75320 = 17'd75320;
  localparam logic [16:0] STC_R_77150 = 17'd77150;
  localparam logic [16:0] STC_R_80000 = 17'd80000;

  // Derating in units of 0.1 % of the programmed target
  localparam logic [9:0] STC_P_0    = 10'd0;
  localparam logic [9:0] STC_P_200  = 10'd200;
  localparam logic [9:0] STC_P_400  = 10'd400;
  localparam logic [9:0] STC_P_943  = 10'd943;
  localparam logic [9:0] STC_P_976  = 10'd976;
  localparam logic [9:0] STC_P_1000 = 10'd1000;

  typedef enum logic [2:0] {
    STC_RGN_NORMAL,
    STC_RGN_WARM,
    STC_RGN_COOL,
    STC_RGN_COLD,
    STC_RGN_HOT,
    STC_RGN_IGNORED
  } stc_region_e;

endpackage

/* File: logic/stc_interval_timer.sv */
`timescale 1ns/10ps
module stc_interval_timer #(
  parameter logic [39:0] PO_A_CYC   = stc_pkg::STC_PO_A_CYC,
  parameter logic [39:0] PO_B_CYC   = stc_pkg::STC_PO_B_CYC,
  parameter logic [39:0] PO_C_CYC   = stc_pkg::STC_PO_C_CYC,
  parameter logic [39:0] SCAN_A_CYC = stc_pkg::STC_SCAN_A_CYC,
  parameter logic [39:0] SCAN_B_CYC = stc_pkg::STC_SCAN_B_CYC,
  parameter logic [39:0] SCAN_C_CYC = stc_pkg::STC_SCAN_C_CYC,
  parameter logic [39:0] SCAN_D_CYC = stc_pkg::STC_SCAN_D_CYC
) (
  input  wire logic       i_clk_sys,   // System clock
  input  wire logic       i_rst_b,     // Async reset, active low
  input  wire logic       i_run,       // Tracking enabled
  input  wire logic       i_restart,   // Restart both timers
  input  wire logic [1:0] i_po_sel,    // Perturb-observe interval code
  input  wire logic [1:0] i_scan_sel,  // Panel scan interval code
  output logic            o_po_tick,   // Perturb-observe step pulse
  output logic            o_scan_tick  // Periodic scan pulse
);
  import stc_pkg::*;

  logic [39:0] po_cnt_r;
  logic [39:0] po_cnt_nxt;
  logic [39:0] scan_cnt_r;
  logic [39:0] scan_cnt_nxt;
  logic [39:0] po_lim;
  logic [39:0] scan_lim;
  logic        po_en;

  // ==========================================================
  // Interval selection
  always_comb begin
    po_en = 1'b1;
    unique case (i_po_sel)
      2'h0: begin
        po_lim = PO_A_CYC;
        po_en  = 1'b0;
      end
      2'h1: po_lim = PO_A_CYC;
      2'h2: po_lim = PO_B_CYC;
      2'h3: po_lim = PO_C_CYC;
    endcase
    unique case (i_scan_sel)
      2'h0: scan_lim = SCAN_A_CYC;
      2'h1: scan_lim = SCAN_B_CYC;
      2'h2: scan_lim = SCAN_C_CYC;
      2'h3: scan_lim = SCAN_D_CYC;
    endcase
  end

  // Counters sit at zero while tracking is off so a later enable starts a full interval
  always_comb begin
    o_po_tick    = i_run && !i_restart && po_en && (po_cnt_r >= po_lim - 40'h1);
    o_scan_tick  = i_run && !i_restart && (scan_cnt_r >= scan_lim - 40'h1);
    po_cnt_nxt   = po_cnt_r + 40'h1;
    scan_cnt_nxt = scan_cnt_r + 40'h1;
    if (!i_run || i_restart || !po_en || o_po_tick) begin
      po_cnt_nxt = '0;
    end
    if (!i_run || i_restart || o_scan_tick) begin
      scan_cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      po_cnt_r   <= '0;
      scan_cnt_r <= '0;
    end else begin
      po_cnt_r   <= po_cnt_nxt;
      scan_cnt_r <= scan_cnt_nxt;
    end
  end

endmodule

/* File: logic/stc_region_decode.sv */
`timescale 1ns/10ps
module stc_region_decode (
  input  wire logic                 i_clk_sys,         // System clock
  input  wire logic                 i_rst_b,           // Async reset, active low
  input  wire logic [16:0]          i_thermistor_input, // Ratio, 0.001 % units
  input  wire logic [7:0]           i_thresh,          // Threshold register
  input  wire logic [7:0]           i_behave,          // Region behaviour register
  input  wire logic [7:0]           i_revts,           // Reverse limits register
  output stc_pkg::stc_region_e      o_region,          // Charging region
  output logic [9:0]                o_voltage_pct,     // Voltage target, 0.1 %
  output logic [9:0]                o_current_pct,     // Current target, 0.1 %
  output logic                      o_charge_suspend,  // Charging suspended
  output logic                      o_reverse_fault    // Reverse-mode limit crossed
);
  import stc_pkg::*;

  logic [16:0] hot_lim, warm_lim, cool_lim, cold_lim, rhot_lim, rcold_lim;
  logic        therm_on, profile_on, rhot_on;
  stc_region_e rgn;
  logic [9:0]  v_pct, i_pct;
  logic        rfault;

  // ==========================================================
  // Threshold lookup
  always_comb begin
    therm_on   = i_behave[STC_B_THERM_ON];
    profile_on = i_behave[STC_B_PROFILE_ON];
    unique case (i_thresh[STC_B_HOT_LO +: 2])
      2'h0: hot_lim = STC_R_41200;
      2'h1: hot_lim = STC_R_37700;
      2'h2: hot_lim = STC_R_34375;
      2'h3: hot_lim = STC_R_31250;
    endcase
    unique case (i_thresh[STC_B_WARM_LO +: 2])
      2'h0: warm_lim = STC_R_48400;
      2'h1: warm_lim = STC_R_44800;
      2'h2: warm_lim = STC_R_41200;
      2'h3: warm_lim = STC_R_37700;
    endcase
    unique case (i_thresh[STC_B_COOL_LO +: 2])
      2'h0: cool_lim = STC_R_71100;
      2'h1: cool_lim = STC_R_68400;
      2'h2: cool_lim = STC_R_65500;
      2'h3: cool_lim = STC_R_62400;
    endcase
    unique case (i_thresh[STC_B_COLD_LO +: 2])
      2'h0: cold_lim = STC_R_77150;
      2'h1: cold_lim = STC_R_75320;
      2'h2: cold_lim = STC_R_73250;
      2'h3: cold_lim = STC_R_71100;
    endcase
    rhot_on = 1'b1;
    unique case (i_revts[STC_B_RHOT_LO +: 2])
      2'h0: rhot_lim = STC_R_37700;
      2'h1: rhot_lim = STC_R_34200;
      2'h2: rhot_lim = STC_R_31250;
      2'h3: begin
        rhot_lim = STC_R_31250;
        rhot_on  = 1'b0;
      end
    endcase
    rcold_lim = i_revts[STC_B_RCOLD] ? STC_R_80000 : STC_R_77150;
  end

  // ==========================================================
  // Region and derating; higher ratio means colder
  always_comb begin
    v_pct = STC_P_1000;
    i_pct = STC_P_1000;
    if (!therm_on) begin
      rgn = STC_RGN_IGNORED;
    end else if (i_thermistor_input > cold_lim) begin
      rgn = STC_RGN_COLD;
    end else if (i_thermistor_input < hot_lim) begin
      rgn = STC_RGN_HOT;
    end else if (profile_on && i_thermistor_input > cool_lim) begin
      rgn = STC_RGN_COOL;
    end else if (profile_on && i_thermistor_input < warm_lim) begin
      rgn = STC_RGN_WARM;
    end else begin
      rgn = STC_RGN_NORMAL;
    end
    unique case (rgn)
      STC_RGN_COLD, STC_RGN_HOT: begin
        v_pct = STC_P_0;
        i_pct = STC_P_0;
      end
      STC_RGN_WARM: begin
        unique case (i_behave[STC_B_WARM_V_LO +: 2])
          2'h0: v_pct = STC_P_0;
          2'h1: v_pct = STC_P_943;
          2'h2: v_pct = STC_P_976;
          2'h3: v_pct = STC_P_1000;
        endcase
        i_pct = i_behave[STC_B_WARM_I] ? STC_P_1000 : STC_P_400;
        if (v_pct == STC_P_0) begin
          i_pct = STC_P_0;
        end
      end
      STC_RGN_COOL: begin
        unique case (i_behave[STC_B_COOL_I_LO +: 2])
          2'h0: i_pct = STC_P_0;
          2'h1: i_pct = STC_P_200;
          2'h2: i_pct = STC_P_400;
          2'h3: i_pct = STC_P_1000;
        endcase
        if (i_pct == STC_P_0) begin
          v_pct = STC_P_0;
        end
      end
      default: begin
        v_pct = STC_P_1000;
        i_pct = STC_P_1000;
      end
    endcase
    rfault = therm_on && ((rhot_on && i_thermistor_input < rhot_lim) ||
                          i_thermistor_input > rcold_lim);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_region         <= STC_RGN_NORMAL;
      o_voltage_pct    <= STC_P_1000;
      o_current_pct    <= STC_P_1000;
      o_charge_suspend <= 1'b0;
      o_reverse_fault  <= 1'b0;
    end else begin
      o_region         <= rgn;
      o_voltage_pct    <= v_pct;
      o_current_pct    <= i_pct;
      o_charge_suspend <= (i_pct == STC_P_0);
      o_reverse_fault  <= rfault;
    end
  end

endmodule

/* File: logic/stc_config_bank.sv */
`timescale 1ns/10ps
module stc_config_bank #(
  parameter logic [39:0] PO_A_CYC   = stc_pkg::STC_PO_A_CYC,   // 0.5 s in cycles
  parameter logic [39:0] PO_B_CYC   = stc_pkg::STC_PO_B_CYC,   // 1 s in cycles
  parameter logic [39:0] PO_C_CYC   = stc_pkg::STC_PO_C_CYC,   // 10 s in cycles
  parameter logic [39:0] SCAN_A_CYC = stc_pkg::STC_SCAN_A_CYC, // 3 min in cycles
  parameter logic [39:0] SCAN_B_CYC = stc_pkg::STC_SCAN_B_CYC, // 10 min in cycles
  parameter logic [39:0] SCAN_C_CYC = stc_pkg::STC_SCAN_C_CYC, // 15 min in cycles
  parameter logic [39:0] SCAN_D_CYC = stc_pkg::STC_SCAN_D_CYC  // 20 min in cycles
) (
  input  wire logic            i_clk_sys,          // System clock, 200 MHz
  input  wire logic            i_rst_b,            // Async reset, active low
  input  wire logic            i_reg_reset,        // Register reset request pulse
  input  wire logic            i_wr_en,            // Register write strobe
  input  wire logic            i_rd_en,            // Register read strobe
  input  wire logic [7:0]      i_addr,             // Register address
  input  wire logic [7:0]      i_wr_data,          // Write data
  output logic [7:0]           o_rd_data,          // Read data, one cycle after strobe
  input  wire logic            i_sweep_done,       // Tracking engine finished a sweep
  input  wire logic            i_adc_wr_en,        // Host write to ADC control register
  output logic                 o_adc_wr_allow,     // ADC control write may land
  output logic                 o_track_on,         // Peak power tracking enabled
  output logic                 o_sweep_start,      // Start a full panel sweep, pulse
  output logic                 o_po_step,          // Perturb-observe step, pulse
  input  wire logic [16:0]     i_thermistor_input, // Thermistor ratio, 0.001 % units
  output stc_pkg::stc_region_e o_region,           // Present charging region
  output logic [9:0]           o_voltage_pct,      // Voltage target, 0.1 % units
  output logic [9:0]           o_current_pct,      // Current target, 0.1 % units
  output logic                 o_charge_suspend,   // Region suspends charging
  output logic                 o_reverse_fault     // Reverse-mode thermistor limit hit
);
  import stc_pkg::*;

  // ==========================================================
  // Register state
  logic [7:0] track_r;
  logic [7:0] track_nxt;
  logic [7:0] thresh_r;
  logic [7:0] thresh_nxt;
  logic [7:0] behave_r;
  logic [7:0] behave_nxt;
  logic [7:0] revts_r;
  logic [7:0] revts_nxt;
  logic [7:0] rd_data_nxt;
  logic       sweep_busy_r;
  logic       sweep_busy_nxt;
  logic       start_r;
  logic       start_nxt;
  logic       po_tick;
  logic       scan_tick;
  logic       wr_track;
  logic       host_sweep;

  // ==========================================================
  // Write decode
  always_comb begin
    wr_track   = i_wr_en && (i_addr == STC_OFS_TRACK);
    host_sweep = wr_track && i_wr_data[STC_B_SWEEP];
    track_nxt  = track_r;
    thresh_nxt = thresh_r;
    behave_nxt = behave_r;
    revts_nxt  = revts_r;
    if (i_wr_en) begin
      unique case (i_addr)
        STC_OFS_TRACK:  track_nxt  = i_wr_data & STC_WM_TRACK;
        STC_OFS_THRESH: thresh_nxt = i_wr_data & STC_WM_THRESH;
        STC_OFS_REGION: behave_nxt = i_wr_data & STC_WM_REGION;
        STC_OFS_REVTS:  revts_nxt  = i_wr_data & STC_WM_REVTS;
        default: begin
          track_nxt = track_r;
        end
      endcase
    end
    // The sweep bit only ever sets from a host write; zero writes leave a running sweep alone
    track_nxt[STC_B_SWEEP] = track_r[STC_B_SWEEP];
    if (i_sweep_done) begin
      track_nxt[STC_B_SWEEP] = 1'b0;
    end
    if (host_sweep) begin
      track_nxt[STC_B_SWEEP] = 1'b1;
    end
    if (i_reg_reset) begin
      track_nxt  = STC_RST_TRACK;
      thresh_nxt = STC_RST_THRESH;
      behave_nxt = STC_RST_REGION;
      revts_nxt  = STC_RST_REVTS;
    end
  end

  // ==========================================================
  // Sweep sequencing
  always_comb begin
    // A periodic scan only fires while tracking runs and no sweep is in flight
    start_nxt      = (host_sweep && !i_reg_reset) ||
                     (scan_tick && !sweep_busy_r && !i_reg_reset);
    sweep_busy_nxt = sweep_busy_r;
    if (i_sweep_done) begin
      sweep_busy_nxt = 1'b0;
    end
    if (start_nxt) begin
      sweep_busy_nxt = 1'b1;
    end
    if (i_reg_reset) begin
      sweep_busy_nxt = 1'b0;
    end
  end

  always_comb begin
    o_track_on     = track_r[STC_B_TRACK_ON];
    o_sweep_start  = start_r;
    o_po_step      = po_tick && !sweep_busy_r;
    o_adc_wr_allow = i_adc_wr_en && !track_r[STC_B_TRACK_ON];
  end

  // ==========================================================
  // Read path
  always_comb begin
    rd_data_nxt = o_rd_data;
    if (i_rd_en) begin
      unique case (i_addr)
        STC_OFS_TRACK:  rd_data_nxt = track_r;
        STC_OFS_THRESH: rd_data_nxt = thresh_r;
        STC_OFS_REGION: rd_data_nxt = behave_r;
        STC_OFS_REVTS:  rd_data_nxt = revts_r;
        default:        rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      track_r      <= STC_RST_TRACK;
      thresh_r     <= STC_RST_THRESH;
      behave_r     <= STC_RST_REGION;
      revts_r      <= STC_RST_REVTS;
      sweep_busy_r <= 1'b0;
      start_r      <= 1'b0;
      o_rd_data    <= 8'h00;
    end else begin
      track_r      <= track_nxt;
      thresh_r     <= thresh_nxt;
      behave_r     <= behave_nxt;
      revts_r      <= revts_nxt;
      sweep_busy_r <= sweep_busy_nxt;
      start_r      <= start_nxt;
      o_rd_data    <= rd_data_nxt;
    end
  end

  // ==========================================================
  // Tracking timers; any sweep start restarts both
  stc_interval_timer #(
    .PO_A_CYC   (PO_A_CYC),
    .PO_B_CYC   (PO_B_CYC),
    .PO_C_CYC   (PO_C_CYC),
    .SCAN_A_CYC (SCAN_A_CYC),
    .SCAN_B_CYC (SCAN_B_CYC),
    .SCAN_C_CYC (SCAN_C_CYC),
    .SCAN_D_CYC (SCAN_D_CYC)
  ) u_timer (
    .i_clk_sys   (i_clk_sys),
    .i_rst_b     (i_rst_b),
    .i_run       (track_r[STC_B_TRACK_ON]),
    .i_restart   (start_r || i_reg_reset),
    .i_po_sel    (track_r[STC_B_PO_LO +: 2]),
    .i_scan_sel  (track_r[STC_B_SCAN_LO +: 2]),
    .o_po_tick   (po_tick),
    .o_scan_tick (scan_tick)
  );

  // ==========================================================
  // Thermistor regions
  stc_region_decode u_region (
    .i_clk_sys          (i_clk_sys),
    .i_rst_b            (i_rst_b),
    .i_thermistor_input (i_thermistor_input),
    .i_thresh           (thresh_r),
    .i_behave           (behave_r),
    .i_revts            (revts_r),
    .o_region           (o_region),
    .o_voltage_pct      (o_voltage_pct),
    .o_current_pct      (o_current_pct),
    .o_charge_suspend   (o_charge_suspend),
    .o_reverse_fault    (o_reverse_fault)
  );

endmodule

/* File: tb/stc_chk.sv */
`timescale 1ns/10ps
// ==========================================================
// Port-level checks of the configuration bank
module stc_chk import stc_pkg::*; (
  input wire logic                 i_clk_sys,        // Clock
  input wire logic                 i_rst_b,          // Reset, active low
  input wire logic                 i_reg_reset,      // Register reset pulse
  input wire logic                 i_wr_en,          // Write strobe
  input wire logic                 i_rd_en,          // Read strobe
  input wire logic [7:0]           i_addr,           // Address
  input wire logic [7:0]           i_wr_data,        // Write data
  input wire logic [7:0]           o_rd_data,        // Read data
  input wire logic                 i_adc_wr_en,      // ADC write request
  input wire logic                 o_adc_wr_allow,   // ADC write let through
  input wire logic                 o_track_on,       // Tracking enabled
  input wire logic                 o_sweep_start,    // Sweep pulse
  input wire logic                 o_po_step,        // Step pulse
  input wire stc_pkg::stc_region_e o_region,         // Region
  input wire logic [9:0]           o_voltage_pct,    // Voltage target
  input wire logic [9:0]           o_current_pct,    // Current target
  input wire logic                 o_charge_suspend, // Suspend flag
  input wire logic                 o_reverse_fault   // Reverse limit flag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic wr_trk;
  // A register reset in the same cycle drops the write
  assign wr_trk = i_wr_en && i_addr == STC_OFS_TRACK && !i_reg_reset;
  a_adc_gate: assert property (o_adc_wr_allow == (i_adc_wr_en && !o_track_on))
    else $error("adc write gate wrong");
  a_track_bit: assert property (wr_trk |=> o_track_on == $past(i_wr_data[0]))
    else $error("tracking enable not taken");
  a_sweep_go: assert property (wr_trk && i_wr_data[7] |=> o_sweep_start)
    else $error("sweep did not start");
  a_reset_def: assert property (i_reg_reset |=> !o_track_on && !o_sweep_start)
    else $error("register reset left state");
  a_step_idle: assert property (!o_track_on |-> !o_po_step)
    else $error("step while tracking off");
  a_unmapped_rd: assert property (i_rd_en && (i_addr < 8'h1a || i_addr > 8'h1d)
    |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
  a_suspend_tie: assert property (o_charge_suspend == (o_current_pct == 10'd0))
    else $error("suspend flag disagrees");
  a_therm_off: assert property (o_region == STC_RGN_IGNORED |-> o_current_pct == STC_P_1000
    && o_voltage_pct == STC_P_1000 && !o_reverse_fault) else $error("ignored not full");
  a_limit_stop: assert property (o_region inside {STC_RGN_COLD, STC_RGN_HOT}
    |-> o_charge_suspend) else $error("cold or hot still charging");
endmodule

bind stc_config_bank stc_chk u_chk (.i_clk_sys, .i_rst_b, .i_reg_reset, .i_wr_en, .i_rd_en,
  .i_addr, .i_wr_data, .o_rd_data, .i_adc_wr_en, .o_adc_wr_allow, .o_track_on,
  .o_sweep_start, .o_po_step, .o_region, .o_voltage_pct, .o_current_pct,
  .o_charge_suspend, .o_reverse_fault);

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import stc_pkg::*;
  // Short interval counts keep the run small
  localparam int         PO[3]  = '{10, 20, 40};
  localparam int         SC[4]  = '{300, 400, 500, 600};
  localparam logic [7:0] RST[4] = '{STC_RST_TRACK, STC_RST_THRESH, STC_RST_REGION, STC_RST_REVTS};
  localparam logic [7:0] WM[4]  = '{STC_WM_TRACK, STC_WM_THRESH, STC_WM_REGION, STC_WM_REVTS};
  localparam logic [16:0] HOTL[4]  = '{STC_R_41200, STC_R_37700, STC_R_34375, STC_R_31250};
  localparam logic [16:0] COLDL[4] = '{STC_R_77150, STC_R_75320, STC_R_73250, STC_R_71100};
  logic        i_clk_sys, i_rst_b, i_reg_reset, i_wr_en, i_rd_en, i_sweep_done, i_adc_wr_en;
  logic [7:0]  i_addr, i_wr_data, o_rd_data, d;
  logic [16:0] i_thermistor_input;
  logic        o_adc_wr_allow, o_track_on, o_sweep_start, o_po_step;
  logic        o_charge_suspend, o_reverse_fault;
  logic [9:0]  o_voltage_pct, o_current_pct;
  stc_region_e o_region;
  int          miscompares = 0, compares = 0, cyc = 0, seed = 32'h7149c9fb, n, k;

  stc_config_bank #(.PO_A_CYC(40'(PO[0])), .PO_B_CYC(40'(PO[1])), .PO_C_CYC(40'(PO[2])),
    .SCAN_A_CYC(40'(SC[0])), .SCAN_B_CYC(40'(SC[1])), .SCAN_C_CYC(40'(SC[2])),
    .SCAN_D_CYC(40'(SC[3]))) uut (.i_clk_sys, .i_rst_b, .i_reg_reset, .i_wr_en, .i_rd_en,
    .i_addr, .i_wr_data, .o_rd_data, .i_sweep_done, .i_adc_wr_en, .o_adc_wr_allow,
    .o_track_on, .o_sweep_start, .o_po_step, .i_thermistor_input, .o_region,
    .o_voltage_pct, .o_current_pct, .o_charge_suspend, .o_reverse_fault);

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Readback after a write: writable bits only, unmapped addresses read zero
  function automatic logic [7:0] exp_rd(input int a, input logic [7:0] v);
    return (a < 4) ? (v & WM[a]) : 8'h00;
  endfunction
  task automatic close_out;
    $display("TB: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1 check(o_rd_data, e);
  endtask
  // Counts edges until the chosen pulse shows, bounded at 2000
  task automatic waitp(input bit s, output int c);
    c = 0;
    do begin
      @(posedge i_clk_sys);
      #1 c++;
    end while ((s ? o_sweep_start : o_po_step) !== 1'b1 && c < 2000);
  endtask
  task automatic rgn(input logic [7:0] a, v, input logic [16:0] t, input stc_region_e r,
                     input logic [9:0] vp, cp, input logic f);
    wr(a, v);
    i_thermistor_input <= t;
    repeat (3) @(posedge i_clk_sys);
    #1 check(o_region, r);
    if (r < STC_RGN_COLD) check(o_voltage_pct, vp);
    check(o_current_pct, cp);
    check(o_charge_suspend, cp == 10'd0);
    check(o_reverse_fault, f);
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    i_adc_wr_en <= 1'($random(seed));
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {i_reg_reset, i_wr_en, i_rd_en, i_sweep_done, i_rst_b, i_addr, i_wr_data} = '0;
    i_thermistor_input = 17'd50000;
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    for (k = 0; k < 4; k++) rdchk(8'(26 + k), RST[k]);
    rdchk(8'h1e, 8'h00);
    $display("test reset values done");
    i_sweep_done <= 1'b1;
    for (n = 0; n < 40; n++) begin
      k = $unsigned($random(seed)) % 5;
      d = 8'($random(seed));
      if (k == 0) d[7] = 1'b0;
      wr(8'(26 + k), d);
      rdchk(8'(26 + k), exp_rd(k, d));
    end
    @(posedge i_clk_sys);
    i_reg_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_reset <= 1'b0;
    for (k = 0; k < 4; k++) rdchk(8'(26 + k), RST[k]);
    $display("test random access done");
    i_sweep_done <= 1'b0;
    wr(8'h1a, 8'h80);
    #1 check(o_sweep_start, 1'b1);
    rdchk(8'h1a, 8'h80);
    i_sweep_done <= 1'b1;
    rdchk(8'h1a, 8'h00);
    $display("test sweep done");
    for (k = 1; k < 4; k++) begin
      wr(8'h1a, 8'(k << 5 | 1));
      waitp(1'b0, n);
      waitp(1'b0, n);
      check(n, PO[k-1]);
    end
    wr(8'h1a, 8'h01);
    waitp(1'b0, n);
    check(n, 2000);
    for (k = 0; k < 4; k++) begin
      wr(8'h1a, 8'(k << 1 | 1));
      waitp(1'b1, n);
      waitp(1'b1, n);
      check(n >= SC[k] && n <= SC[k] + 2, 1'b1);
    end
    wr(8'h1a, 8'h20);
    $display("test intervals done");
    rgn(8'h1c, 8'h57, 50000, STC_RGN_NORMAL, 1000, 1000, 0);
    rgn(8'h1c, 8'h57, 80000, STC_RGN_COLD, 0, 0, 1);
    rgn(8'h1c, 8'h57, 30000, STC_RGN_HOT, 0, 0, 1);
    rgn(8'h1c, 8'h57, 70000, STC_RGN_COOL, 1000, 200, 0);
    rgn(8'h1c, 8'h57, 40000, STC_RGN_WARM, 976, 1000, 0);
    rgn(8'h1c, 8'h47, 40000, STC_RGN_WARM, 976, 400, 0);
    rgn(8'h1c, 8'h37, 40000, STC_RGN_WARM, 943, 1000, 0);
    rgn(8'h1c, 8'h77, 40000, STC_RGN_WARM, 1000, 1000, 0);
    rgn(8'h1c, 8'h17, 40000, STC_RGN_WARM, 0, 0, 0);
    rgn(8'h1c, 8'h5b, 70000, STC_RGN_COOL, 1000, 400, 0);
    rgn(8'h1c, 8'h5f, 70000, STC_RGN_COOL, 1000, 1000, 0);
    rgn(8'h1c, 8'h53, 70000, STC_RGN_COOL, 0, 0, 0);
    rgn(8'h1b, 8'hd6, 33000, STC_RGN_WARM, 976, 1000, 1);
    rgn(8'h1c, 8'h55, 70000, STC_RGN_NORMAL, 1000, 1000, 0);
    rgn(8'h1d, 8'h60, 80000, STC_RGN_COLD, 0, 0, 0);
    rgn(8'h1d, 8'hc0, 30000, STC_RGN_HOT, 0, 0, 0);
    rgn(8'h1d, 8'h80, 30000, STC_RGN_HOT, 0, 0, 1);
    // Every threshold code: one step past the hot and the cold limit
    for (k = 0; k < 4; k++) begin
      d = 8'(k * 8'h55);
      rgn(8'h1b, d, HOTL[k] - 17'd1, STC_RGN_HOT, 0, 0, HOTL[k] <= STC_R_31250);
      rgn(8'h1b, d, COLDL[k] + 17'd1, STC_RGN_COLD, 0, 0, COLDL[k] >= STC_R_77150);
    end
    rgn(8'h1c, 8'h56, 30000, STC_RGN_IGNORED, 1000, 1000, 0);
    $display("test regions done");
    close_out();
  end
endmodule
